// >>> calibration_coefficient_defs.svh
`ifndef CALIBRATION_COEFFICIENT_DEFS_SVH
`define CALIBRATION_COEFFICIENT_DEFS_SVH

// Register indices; byte address is four times the index
`define CURRENT1_GAIN_IDX          6'h21
`define VOLTAGE1_DC_OFFSET_IDX     6'h22
`define VOLTAGE1_GAIN_IDX          6'h23
`define ACTIVE_POWER1_OFFSET_IDX   6'h24
`define CURRENT1_AC_OFFSET_IDX     6'h25
`define REACTIVE_POWER1_OFFSET_IDX 6'h26
`define CURRENT2_GAIN_IDX          6'h28
`define VOLTAGE2_DC_OFFSET_IDX     6'h29
`define VOLTAGE2_GAIN_IDX          6'h2A
`define ACTIVE_POWER2_OFFSET_IDX   6'h2B
`define CURRENT2_AC_OFFSET_IDX     6'h2C
`define REACTIVE_POWER2_OFFSET_IDX 6'h2D
`define TEMPERATURE_GAIN_IDX       6'h36
`define TEMPERATURE_OFFSET_IDX     6'h37
`define CAL_STATUS_IDX             6'h3F

// Reset values
`define ZERO_RESET                 24'h000000
`define UNITY_GAIN_RESET           24'h400000
`define TEMPERATURE_GAIN_RESET     24'h06B716
`define TEMPERATURE_OFFSET_RESET   24'hD53998

// Fixed-point layout
`define GAIN_FRAC_BITS             22
`define TEMP_FRAC_BITS             16
`define RECIP_LIMIT                24'h100000
`define RECIP_STEPS                5'h18
`define POS_FULL                   24'h7FFFFF
`define NEG_FULL                   24'h800000
`define UNSIGNED_FULL              24'hFFFFFF

`endif

// >>> calibration_coefficient_pkg.sv
package calibration_coefficient_pkg;

  typedef enum logic [2:0] {
    CAL_IDLE   = 3'b001,
    CAL_DIVIDE = 3'b010,
    CAL_STORE  = 3'b100
  } cal_state_e;

  typedef enum logic [1:0] {
    CAL_KIND_DC_OFFSET = 2'h1,
    CAL_KIND_GAIN      = 2'h2
  } cal_kind_e;

  typedef logic [23:0] coef_t;

endpackage : calibration_coefficient_pkg

// >>> calibration_coefficient_regs.sv
`timescale 1ns/1ps
`include "calibration_coefficient_defs.svh"
`default_nettype none

module calibration_coefficient_regs
  import calibration_coefficient_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              reset_n,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [31:0]       wb_dat_i,
  input  wire logic [3:0]        wb_sel_i,
  output var  logic [31:0]       wb_dat_o,
  output var  logic              wb_ack_o,
  input  wire logic              calStart,
  input  wire logic [1:0]        calKind,
  input  wire logic [3:0]        calSelect,
  input  wire logic [23:0]       calMeasured,
  output var  logic              calBusy,
  output var  logic              calDone,
  input  wire logic              sampleValid,
  input  wire logic [3:0][23:0]  rawSample,
  output var  logic [3:0][23:0]  correctedSample,
  input  wire logic              powerValid,
  input  wire logic [3:0][23:0]  rawPower,
  output var  logic [3:0][23:0]  averagedPower,
  input  wire logic              rmsValid,
  input  wire logic [1:0][23:0]  rawCurrentRms,
  output var  logic [1:0][23:0]  correctedCurrentRms,
  input  wire logic              tempValid,
  input  wire logic [23:0]       rawTemperature,
  output var  logic [23:0]       scaledTemperature
);

  // Slots: 0 I1 gain, 1 V1 dc, 2 V1 gain, 3 P1 off, 4 I1 ac, 5 Q1 off,
  // 6 I2 gain, 7 V2 dc, 8 V2 gain, 9 P2 off, 10 I2 ac, 11 Q2 off, 12 T gain, 13 T off
  localparam int NUM_COEF = 14;

  coef_t      coefReg [NUM_COEF];
  cal_state_e calState_reg;
  logic [4:0] stepCount_reg;
  logic [24:0] remainder_reg;
  logic [23:0] quotient_reg;
  logic [23:0] calResult_reg;
  logic [1:0]  calKind_reg;
  logic [3:0]  calSelect_reg;
  logic        busHit;
  logic [3:0]  busSlot;
  logic        busWrite;
  logic [24:0] remainder_next;
  logic [23:0] calMeasuredHold;

  function automatic coef_t resetValue(input int slot);
    case (slot)
      0, 2, 6, 8: resetValue = `UNITY_GAIN_RESET;
      12:         resetValue = `TEMPERATURE_GAIN_RESET;
      13:         resetValue = `TEMPERATURE_OFFSET_RESET;
      default:    resetValue = `ZERO_RESET;
    endcase
  endfunction : resetValue

  function automatic coef_t sat24(input logic signed [51:0] value);
    if (value > $signed({28'h0, `POS_FULL})) begin
      sat24 = `POS_FULL;
    end else if (value < $signed({{28{1'b1}}, `NEG_FULL})) begin
      sat24 = `NEG_FULL;
    end else begin
      sat24 = value[23:0];
    end
  endfunction : sat24

  // Address decode
  always_comb begin
    busHit  = 1'b1;
    busSlot = 4'h0;
    case (wb_adr_i[7:2])
      `CURRENT1_GAIN_IDX:          busSlot = 4'h0;
      `VOLTAGE1_DC_OFFSET_IDX:     busSlot = 4'h1;
      `VOLTAGE1_GAIN_IDX:          busSlot = 4'h2;
      `ACTIVE_POWER1_OFFSET_IDX:   busSlot = 4'h3;
      `CURRENT1_AC_OFFSET_IDX:     busSlot = 4'h4;
      `REACTIVE_POWER1_OFFSET_IDX: busSlot = 4'h5;
      `CURRENT2_GAIN_IDX:          busSlot = 4'h6;
      `VOLTAGE2_DC_OFFSET_IDX:     busSlot = 4'h7;
      `VOLTAGE2_GAIN_IDX:          busSlot = 4'h8;
      `ACTIVE_POWER2_OFFSET_IDX:   busSlot = 4'h9;
      `CURRENT2_AC_OFFSET_IDX:     busSlot = 4'hA;
      `REACTIVE_POWER2_OFFSET_IDX: busSlot = 4'hB;
      `TEMPERATURE_GAIN_IDX:       busSlot = 4'hC;
      `TEMPERATURE_OFFSET_IDX:     busSlot = 4'hD;
      default:                     busHit  = 1'b0;
    endcase
  end

  // Ack gates the write so a strobe held into the ack cycle cannot write twice
  assign busWrite = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && busHit;

  // Single-cycle ack; unmapped reads give zero, unmapped writes vanish
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
    end
  end

  // Read data registered with the ack so it stands through the ack cycle
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      wb_dat_o <= 32'h00000000;
    end else if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
      if (busHit) begin
        wb_dat_o <= {8'h00, coefReg[busSlot]};
      end else if (wb_adr_i[7:2] == `CAL_STATUS_IDX) begin
        wb_dat_o <= {30'h0, calDone, calBusy};
      end else begin
        wb_dat_o <= 32'h00000000;
      end
    end
  end

  // Coefficient storage; a calibration store beats a host write in the same cycle
  generate
    for (genvar s = 0; s < NUM_COEF; s++) begin : g_coef
      localparam bit IS_DC   = (s == 1) || (s == 7);
      localparam bit IS_GAIN = (s == 0) || (s == 2) || (s == 6) || (s == 8);
      localparam int CAL_BIT = (s == 0) ? 0 : (s == 1 || s == 2) ? 1 : (s == 6) ? 2 : 3;
      logic calHit;
      assign calHit = (calState_reg == CAL_STORE) && calSelect_reg[CAL_BIT] &&
                      ((IS_DC && calKind_reg == CAL_KIND_DC_OFFSET) ||
                       (IS_GAIN && calKind_reg == CAL_KIND_GAIN));
      always_ff @(posedge core_clk) begin
        if (!reset_n) begin
          coefReg[s] <= resetValue(s);
        end else if (calHit) begin
          coefReg[s] <= calResult_reg;
        end else if (busWrite && busSlot == 4'(s)) begin
          for (int b = 0; b < 3; b++) begin
            if (wb_sel_i[b]) begin
              coefReg[s][8*b +: 8] <= wb_dat_i[8*b +: 8];
            end
          end
        end
      end
    end
  endgenerate

  // Calibration sequencer: negate for offset, long division for reciprocal
  assign remainder_next = {remainder_reg[23:0], 1'b0};

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      calState_reg  <= CAL_IDLE;
      stepCount_reg <= 5'h00;
      remainder_reg <= 25'h0;
      quotient_reg  <= 24'h0;
      calResult_reg <= 24'h0;
    end else begin
      case (calState_reg)
        CAL_IDLE: begin
          if (calStart) begin
            if (calKind == CAL_KIND_GAIN) begin
              // Gains at or below 0.25 would overflow 4.0; clamp to full scale
              if (calMeasured <= `RECIP_LIMIT) begin
                calResult_reg <= `UNSIGNED_FULL;
                calState_reg  <= CAL_STORE;
              end else begin
                remainder_reg <= {1'b0, `RECIP_LIMIT};
                quotient_reg  <= 24'h0;
                stepCount_reg <= `RECIP_STEPS;
                calState_reg  <= CAL_DIVIDE;
              end
            end else begin
              // Negating full negative scale saturates, range stops short of 1.0
              calResult_reg <= (calMeasured == `NEG_FULL) ? `POS_FULL :
                               24'(-calMeasured);
              calState_reg  <= CAL_STORE;
            end
          end
        end
        CAL_DIVIDE: begin
          if (remainder_next >= {1'b0, calMeasuredHold}) begin
            remainder_reg <= remainder_next - {1'b0, calMeasuredHold};
            quotient_reg  <= {quotient_reg[22:0], 1'b1};
          end else begin
            remainder_reg <= remainder_next;
            quotient_reg  <= {quotient_reg[22:0], 1'b0};
          end
          stepCount_reg <= stepCount_reg - 5'h01;
          if (stepCount_reg == 5'h01) begin
            calState_reg <= CAL_STORE;
          end
        end
        CAL_STORE: begin
          calState_reg <= CAL_IDLE;
        end
        default: begin
          calState_reg <= CAL_IDLE;
        end
      endcase
      if (calState_reg == CAL_DIVIDE && stepCount_reg == 5'h01) begin
        // 2^44 / G in 2.22 format
        calResult_reg <= (remainder_next >= {1'b0, calMeasuredHold}) ?
                         {quotient_reg[22:0], 1'b1} : {quotient_reg[22:0], 1'b0};
      end
    end
  end

  // Divisor held so the measurement port may change mid-division
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      calMeasuredHold <= 24'h0;
    end else if (calState_reg == CAL_IDLE && calStart) begin
      calMeasuredHold <= calMeasured;
    end
  end

  // Kind and select latched at start; the request inputs may move mid-divide
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      calKind_reg   <= 2'h0;
      calSelect_reg <= 4'h0;
    end else if (calState_reg == CAL_IDLE && calStart) begin
      calKind_reg   <= calKind;
      calSelect_reg <= calSelect;
    end
  end

  // Busy rises on the taken start and falls with the store
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      calBusy <= 1'b0;
    end else begin
      calBusy <= (calState_reg == CAL_IDLE) ? calStart : (calState_reg != CAL_STORE);
    end
  end

  // One-cycle done pulse in the cycle after the store
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      calDone <= 1'b0;
    end else begin
      calDone <= (calState_reg == CAL_STORE);
    end
  end

  // Instantaneous path: channel 0 I1, 1 V1, 2 I2, 3 V2
  generate
    for (genvar c = 0; c < 4; c++) begin : g_sample
      localparam int GAIN_SLOT = (c == 0) ? 0 : (c == 1) ? 2 : (c == 2) ? 6 : 8;
      localparam int DC_SLOT   = (c == 3) ? 7 : 1;
      localparam bit HAS_DC    = (c == 1) || (c == 3);
      logic signed [51:0] withOffset;
      logic signed [51:0] scaled;
      always_comb begin
        withOffset = 52'(signed'(rawSample[c]));
        if (HAS_DC) begin
          withOffset = withOffset + 52'(signed'(coefReg[DC_SLOT]));
        end
        withOffset = 52'(signed'(sat24(withOffset)));
        // Gain is unsigned 2.22, so zero-extend before the multiply
        scaled = (withOffset * $signed({28'h0, coefReg[GAIN_SLOT]})) >>>
                 `GAIN_FRAC_BITS;
      end
      always_ff @(posedge core_clk) begin
        if (!reset_n) begin
          correctedSample[c] <= 24'h0;
        end else if (sampleValid) begin
          correctedSample[c] <= sat24(scaled);
        end
      end
    end
  endgenerate

  // Averaged power: 0 P1, 1 Q1, 2 P2, 3 Q2
  generate
    for (genvar p = 0; p < 4; p++) begin : g_power
      localparam int OFF_SLOT = (p == 0) ? 3 : (p == 1) ? 5 : (p == 2) ? 9 : 11;
      logic signed [51:0] powerSum;
      assign powerSum = 52'(signed'(rawPower[p])) + 52'(signed'(coefReg[OFF_SLOT]));
      always_ff @(posedge core_clk) begin
        if (!reset_n) begin
          averagedPower[p] <= 24'h0;
        end else if (powerValid) begin
          averagedPower[p] <= sat24(powerSum);
        end
      end
    end
  endgenerate

  // RMS current: the AC offset is subtracted and the result floored at zero
  generate
    for (genvar r = 0; r < 2; r++) begin : g_rms
      localparam int AC_SLOT = (r == 0) ? 4 : 10;
      always_ff @(posedge core_clk) begin
        if (!reset_n) begin
          correctedCurrentRms[r] <= 24'h0;
        end else if (rmsValid) begin
          correctedCurrentRms[r] <= (rawCurrentRms[r] > coefReg[AC_SLOT]) ?
                                    rawCurrentRms[r] - coefReg[AC_SLOT] : 24'h0;
        end
      end
    end
  endgenerate

  // Temperature: signed 8.16 times unsigned 8.16, then signed offset
  logic signed [51:0] tempScaled;
  always_comb begin
    tempScaled = (52'(signed'(rawTemperature)) * $signed({28'h0, coefReg[12]})) >>>
                 `TEMP_FRAC_BITS;
    tempScaled = tempScaled + 52'(signed'(coefReg[13]));
  end

  // Saturated so an extreme gain cannot wrap the sign
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      scaledTemperature <= 24'h0;
    end else if (tempValid) begin
      scaledTemperature <= sat24(tempScaled);
    end
  end

endmodule : calibration_coefficient_regs

`default_nettype wire

// >>> calibration_coefficient_regs_chk.sv
`timescale 1ns/1ps
`default_nettype none
module calibration_coefficient_regs_chk (
  input wire logic             core_clk,
  input wire logic             reset_n,
  input wire logic             wb_cyc_i,
  input wire logic             wb_stb_i,
  input wire logic             wb_we_i,
  input wire logic [31:0]      wb_dat_o,
  input wire logic             wb_ack_o,
  input wire logic             calStart,
  input wire logic [1:0]       calKind,
  input wire logic             calBusy,
  input wire logic             calDone,
  input wire logic             sampleValid,
  input wire logic [3:0][23:0] correctedSample,
  input wire logic             powerValid,
  input wire logic [3:0][23:0] averagedPower,
  input wire logic             rmsValid,
  input wire logic [1:0][23:0] rawCurrentRms,
  input wire logic [1:0][23:0] correctedCurrentRms
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // Idle sequencer only; a start while busy is ignored
  sequence calTaken(k);
    calStart && !calBusy && !calDone && calKind == k;
  endsequence
  AST_ACK_NEXT: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("bus request not acknowledged next cycle");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus ack longer than one cycle");
  AST_DAT_WIDTH: assert property (wb_ack_o |-> wb_dat_o[31:24] == 8'h00)
    else $error("read data above bit 23 not zero");
  AST_DC_CAL: assert property (calTaken(2'h1) |=> calBusy ##1 (calDone && !calBusy))
    else $error("offset calibration timing wrong");
  AST_GAIN_CAL: assert property (calTaken(2'h2) |=> calBusy ##[1:26] calDone)
    else $error("gain calibration did not finish");
  AST_DONE_PULSE: assert property (calDone |-> !calBusy ##1 !calDone)
    else $error("done pulse malformed");
  AST_SAMPLE_HOLD: assert property (!sampleValid |=> $stable(correctedSample))
    else $error("corrected sample moved without valid");
  AST_POWER_HOLD: assert property (!powerValid |=> $stable(averagedPower))
    else $error("averaged power moved without valid");
  AST_RMS_FLOOR: assert property (rmsValid |=> correctedCurrentRms[0] <= $past(rawCurrentRms[0])
    && correctedCurrentRms[1] <= $past(rawCurrentRms[1]))
    else $error("rms correction exceeded raw value");
  COV_READ: cover property (wb_ack_o && !wb_we_i);
  COV_DC: cover property (calTaken(2'h1));
  COV_GAIN: cover property (calTaken(2'h2));
endmodule : calibration_coefficient_regs_chk
bind calibration_coefficient_regs calibration_coefficient_regs_chk u_chk (.core_clk, .reset_n,
  .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_dat_o, .wb_ack_o, .calStart, .calKind, .calBusy,
  .calDone, .sampleValid, .correctedSample, .powerValid, .averagedPower, .rmsValid,
  .rawCurrentRms, .correctedCurrentRms);
`default_nettype wire

// >>> calibration_coefficient_regs_fix.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// >>> testbench.sv
`timescale 1ns/1ps
`include "calibration_coefficient_defs.svh"
`default_nettype none
module testbench
  import calibration_coefficient_pkg::*;
;
  logic             core_clk, reset_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic             calStart, calBusy, calDone, sampleValid, powerValid, rmsValid, tempValid;
  logic [7:0]       wb_adr_i;
  logic [31:0]      wb_dat_i, wb_dat_o;
  logic [3:0]       wb_sel_i, calSelect;
  logic [1:0]       calKind;
  coef_t            calMeasured, rawTemperature, scaledTemperature;
  logic [3:0][23:0] rawSample, correctedSample, rawPower, averagedPower;
  logic [1:0][23:0] rawCurrentRms, correctedCurrentRms;
  typedef struct { int k; logic [95:0] v; } exp_s;
  exp_s             expQ[$];
  int               checked, badCount, vPrev;
  logic [95:0]      e;
  coef_t            v[14], o[4];
  logic [5:0]       idxT[14] = '{`CURRENT1_GAIN_IDX, `VOLTAGE1_DC_OFFSET_IDX, `VOLTAGE1_GAIN_IDX,
    `ACTIVE_POWER1_OFFSET_IDX, `CURRENT1_AC_OFFSET_IDX, `REACTIVE_POWER1_OFFSET_IDX,
    `CURRENT2_GAIN_IDX, `VOLTAGE2_DC_OFFSET_IDX, `VOLTAGE2_GAIN_IDX, `ACTIVE_POWER2_OFFSET_IDX,
    `CURRENT2_AC_OFFSET_IDX, `REACTIVE_POWER2_OFFSET_IDX, `TEMPERATURE_GAIN_IDX,
    `TEMPERATURE_OFFSET_IDX};
  coef_t            rstT[14] = '{24'h400000, 24'h0, 24'h400000, 24'h0, 24'h0, 24'h0, 24'h400000,
    24'h0, 24'h400000, 24'h0, 24'h0, 24'h0, 24'h06B716, 24'hD53998};
  calibration_coefficient_regs u_calibration_coefficient_regs (.core_clk, .reset_n, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o, .calStart,
    .calKind, .calSelect, .calMeasured, .calBusy, .calDone, .sampleValid, .rawSample,
    .correctedSample, .powerValid, .rawPower, .averagedPower, .rmsValid, .rawCurrentRms,
    .correctedCurrentRms, .tempValid, .rawTemperature, .scaledTemperature);
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  task automatic endSim();
    check("pending results", 96'(expQ.size()), 96'h0);
    $display("checks %0d mismatches %0d", checked, badCount);
    if (badCount == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : endSim
  task automatic check(input string what, input logic [95:0] seen, input logic [95:0] want);
    checked++;
    if (seen !== want) begin
      badCount++;
      $display("wrong value %s expected %h seen %h", what, want, seen);
    end
  endtask : check
  // Results are matched in order of issue; one transfer in flight at a time
  task automatic take();
    exp_s x;
    if (expQ.size() == 0) begin
      check("result queue", 96'h1, 96'h0);
      return;
    end
    x = expQ.pop_front();
    case (x.k)
      0: check("read data", {64'h0, wb_dat_o}, x.v);
      1: check("averaged power", averagedPower, x.v);
      2: check("corrected sample", correctedSample, x.v);
      3: check("current rms", {48'h0, correctedCurrentRms}, x.v);
      default: check("temperature", {72'h0, scaledTemperature}, x.v);
    endcase
  endtask : take
  initial forever begin
    @(negedge core_clk);
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) take();
    if (vPrev != 0) take();
    vPrev = sampleValid | powerValid | rmsValid | tempValid;
  end
  task automatic bus(input logic we, input logic [5:0] idx, input logic [31:0] d,
                     input logic [3:0] sel);
    int n;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= d;
    wb_sel_i <= sel;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      check("bus ack", 96'h0, 96'h1);
      endSim();
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge core_clk);
  endtask : bus
  task automatic rd(input logic [5:0] idx, input coef_t want);
    expQ.push_back('{0, {72'h0, want}});
    bus(1'b0, idx, 32'h0, 4'hF);
  endtask : rd
  task automatic pulse(input int k, input logic [95:0] want);
    expQ.push_back('{k, want});
    sampleValid <= (k == 2);
    powerValid  <= (k == 1);
    rmsValid    <= (k == 3);
    tempValid   <= (k == 4);
    @(posedge core_clk);
    {sampleValid, powerValid, rmsValid, tempValid} <= 4'h0;
    repeat (2) @(posedge core_clk);
  endtask : pulse
  task automatic cal(input logic [1:0] k, input logic [3:0] sel, input coef_t m);
    int n;
    calKind     <= k;
    calSelect   <= sel;
    calMeasured <= m;
    calStart    <= 1'b1;
    @(posedge core_clk);
    calStart <= 1'b0;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (calDone !== 1'b1 && n < 40);
    if (n >= 40) begin
      check("calibration done", 96'h0, 96'h1);
      endSim();
    end
  endtask : cal
  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, calStart, sampleValid, powerValid, rmsValid, tempValid} = 8'h0;
    {wb_adr_i, wb_dat_i, wb_sel_i, calSelect, calKind, calMeasured, rawTemperature} = 98'h0;
    {rawSample, rawPower, rawCurrentRms} = 240'h0;
    reset_n = 1'b0;
    void'($urandom(32'h3AC3AD5D));
    repeat (12) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    foreach (idxT[i]) rd(idxT[i], rstT[i]);
    $display("test reset values done");
    foreach (idxT[i]) begin
      v[i] = coef_t'($urandom);
      bus(1'b1, idxT[i], $urandom, 4'hF);
      bus(1'b1, idxT[i], {8'hA5, v[i]}, 4'hF);
      rd(idxT[i], v[i]);
    end
    bus(1'b1, idxT[0], 32'hAABBCCDD, 4'b0010);
    rd(idxT[0], {v[0][23:16], 8'hCC, v[0][7:0]});
    bus(1'b1, 6'h30, $urandom, 4'hF);
    rd(6'h30, 24'h0);
    $display("test host access done");
    o[0] = coef_t'($urandom);
    o[1] = 24'h800000;
    for (int j = 0; j < 2; j++) begin
      cal(2'h1, 4'b1010, o[j]);
      e[23:0] = (o[j] == 24'h800000) ? 24'h7FFFFF : -o[j];
      rd(`VOLTAGE1_DC_OFFSET_IDX, e[23:0]);
      rd(`VOLTAGE2_DC_OFFSET_IDX, e[23:0]);
    end
    cal(2'h3, 4'hF, coef_t'($urandom));
    rd(`VOLTAGE1_DC_OFFSET_IDX, e[23:0]);
    rd(`CAL_STATUS_IDX, 24'h0);
    cal(2'h2, 4'b0001, 24'h200000);
    rd(`CURRENT1_GAIN_IDX, 24'h800000);
    cal(2'h2, 4'b1000, 24'h100000);
    rd(`VOLTAGE2_GAIN_IDX, 24'hFFFFFF);
    $display("test calibration done");
    for (int c = 0; c < 4; c++) begin
      o[c] = coef_t'($urandom) & 24'h0FFFFF;
      rawPower[c] <= coef_t'($urandom) & 24'h0FFFFF;
      bus(1'b1, idxT[c * 2 + 3 + ((c > 1) ? 2 : 0)], {8'h0, o[c]}, 4'hF);
    end
    foreach (o[c]) e[c * 24 +: 24] = rawPower[c] + o[c];
    pulse(1, e);
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, idxT[c * 2 + ((c > 1) ? 2 : 0)], 32'h400000, 4'hF);
      o[c] = coef_t'($urandom) & 24'h0FFFFF;
      rawSample[c] <= o[c];
      e[c * 24 +: 24] = o[c] + ((c % 2) ? 24'h001000 : 24'h0);
    end
    bus(1'b1, `VOLTAGE1_DC_OFFSET_IDX, 32'h001000, 4'hF);
    bus(1'b1, `VOLTAGE2_DC_OFFSET_IDX, 32'h001000, 4'hF);
    pulse(2, e);
    bus(1'b1, `CURRENT1_AC_OFFSET_IDX, 32'h000100, 4'hF);
    bus(1'b1, `CURRENT2_AC_OFFSET_IDX, 32'h0, 4'hF);
    o[0] = coef_t'($urandom);
    rawCurrentRms <= {o[0], 24'h000050};
    pulse(3, {48'h0, o[0], 24'h0});
    bus(1'b1, `TEMPERATURE_GAIN_IDX, 32'h020000, 4'hF);
    bus(1'b1, `TEMPERATURE_OFFSET_IDX, 32'h010000, 4'hF);
    o[1] = coef_t'($urandom) & 24'h00FFFF;
    rawTemperature <= o[1];
    pulse(4, {72'h0, (o[1] << 1) + 24'h010000});
    $display("test datapath done");
    endSim();
  end
endmodule : testbench
`default_nettype wire
